// >>> ptc_pkg.sv
// Constants, field layout and types for the transmit timestamp capture block.
// Assumes a 32-bit APB register bus and a single pclk domain.
package ptc_pkg;

  // Register byte offsets
  localparam logic [11:0] PTC_OFF_BANK_PORT_SEL  = 12'h100;
  localparam logic [11:0] PTC_OFF_UNIT_CTRL      = 12'h104;
  localparam logic [11:0] PTC_OFF_CAPTURE_STATUS = 12'h108;
  localparam logic [11:0] PTC_OFF_EVENT_STATUS   = 12'h10C;
  localparam logic [11:0] PTC_OFF_EVENT_MASK     = 12'h110;
  localparam logic [11:0] PTC_OFF_TX_MOD         = 12'h164;
  localparam logic [11:0] PTC_OFF_TX_MOD2        = 12'h168;
  localparam logic [11:0] PTC_OFF_EGRESS_SEC     = 12'h16C;
  localparam logic [11:0] PTC_OFF_EGRESS_NS      = 12'h170;
  localparam logic [11:0] PTC_OFF_MSG_HEADER     = 12'h174;
  localparam logic [11:0] PTC_OFF_DREQ_SEC       = 12'h178;
  localparam logic [11:0] PTC_OFF_DREQ_NS        = 12'h17C;

  // Bank holding the per-port transmit registers
  localparam logic [2:0]  PTC_PORT_BANK          = 3'h2;

  // Field positions
  localparam int PTC_SYNC_INSERT_BIT   = 28;
  localparam int PTC_PDRESP_INSERT_BIT = 29;
  localparam int PTC_PORT_SEL_LSB      = 4;

  // Reset values
  localparam logic [15:0] PTC_CF_MASK_RST        = 16'h000F;

  // Message types
  localparam logic [3:0]  PTC_MSG_SYNC           = 4'h0;
  localparam logic [3:0]  PTC_MSG_DELAY_REQ      = 4'h1;
  localparam logic [3:0]  PTC_MSG_PDELAY_RESP    = 4'h3;

  // Capture buffer geometry
  localparam int PTC_FIFO_DEPTH = 4;
  localparam int PTC_CNT_W      = 3;
  localparam int PTC_NS_W       = 30;
  localparam int PTC_DREQ_SEC_W = 4;
  localparam int PTC_CRC_W      = 12;
  localparam int PTC_SRC_ID_W   = 80;
  localparam logic [11:0] PTC_CRC_POLY = 12'h80F;

  // Event status bits
  localparam int PTC_EV_CAPTURE  = 0;
  localparam int PTC_EV_OVERFLOW = 1;
  localparam int PTC_EV_DREQ     = 2;
  localparam int PTC_EV_W        = 3;

  typedef struct packed {
    logic [31:0]          sec;
    logic [PTC_NS_W-1:0]  ns;
    logic [31:0]          header;
  } ptc_capture_t;

endpackage : ptc_pkg

// >>> ptc_fifo_if.sv
// Interface between the register block and the capture buffer.
// Assumes both ends run on pclk.
`timescale 1ns/100ps
`default_nettype none
interface ptc_fifo_if;
  import ptc_pkg::*;
  logic                 push;
  logic                 pop;
  ptc_capture_t         wdata;
  ptc_capture_t         rdata;
  logic [PTC_CNT_W-1:0] count;
  logic                 full;

  modport producer (output push, output pop, output wdata,
                    input rdata, input count, input full);
  modport store    (input push, input pop, input wdata,
                    output rdata, output count, output full);
endinterface : ptc_fifo_if
`default_nettype wire

// >>> ptc_capture_fifo.sv
// Four-entry first-in first-out store of transmit captures.
// Assumes the producer never pushes when full; pop when empty is ignored.
`timescale 1ns/100ps
`default_nettype none
module ptc_capture_fifo
  import ptc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  ptc_fifo_if.store fif
);

  ptc_capture_t         mem_r [PTC_FIFO_DEPTH];
  logic [1:0]           wr_ptr_r;
  logic [1:0]           rd_ptr_r;
  logic [PTC_CNT_W-1:0] count_r;
  logic                 do_push;
  logic                 do_pop;

  assign do_push = fif.push && (count_r != PTC_CNT_W'(PTC_FIFO_DEPTH));
  assign do_pop  = fif.pop && (count_r != '0);

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= fif.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) wr_ptr_r <= wr_ptr_r + 2'h1;
      if (do_pop)  rd_ptr_r <= rd_ptr_r + 2'h1;
      count_r <= count_r + PTC_CNT_W'(do_push) - PTC_CNT_W'(do_pop);
    end
  end

  // Empty buffer reads as zero
  assign fif.rdata = (count_r == '0) ? '0 : mem_r[rd_ptr_r];
  assign fif.count = count_r;
  assign fif.full  = (count_r == PTC_CNT_W'(PTC_FIFO_DEPTH));

endmodule : ptc_capture_fifo
`default_nettype wire

// >>> ptc_port_crc.sv
// 12-bit CRC over the 80-bit sourcePortIdentity, combinational.
// Assumes the identity is presented most significant octet first.
`timescale 1ns/100ps
`default_nettype none
module ptc_port_crc
  import ptc_pkg::*;
(
  input  wire logic [PTC_SRC_ID_W-1:0] src_id,
  output var  logic [PTC_CRC_W-1:0]    crc
);

  always_comb begin
    logic [PTC_CRC_W-1:0] c;
    logic                 fb;
    c  = '0;
    fb = 1'b0;
    for (int i = PTC_SRC_ID_W - 1; i >= 0; i--) begin
      fb = c[PTC_CRC_W-1] ^ src_id[i];
      c  = {c[PTC_CRC_W-2:0], 1'b0};
      if (fb) c = c ^ PTC_CRC_POLY;
    end
    crc = c;
  end

endmodule : ptc_port_crc
`default_nettype wire

// >>> ptc_tx_capture.sv
// Per-port transmit timestamp capture and frame modification control.
// Assumes frame and egress-time inputs come from logic on pclk.
//
// Summary of operation
// R1: Per-type mask selects correction field modification
// R2: Clear UDP/IPv4 checksum on insertion when enabled
// R3: Software keeps checksum bit while unit enabled
// R4: Each capture has 32-bit seconds, read only
// R5: Four captures buffered, seconds, nanoseconds, header
// R6: Captures valid only while count is nonzero
// R7: Nanoseconds 30 bits, top two bits reserved
// R8: Header top twelve bits hold source CRC
// R9: Header holds message kind and sequence number
// R10: Last Delay_Req egress time kept, 4-bit seconds
// R11: Stored Delay_Req time feeds Delay_Resp insertion
// R12: Bank and port select reach per-port registers
// R13: Buffer is first-in first-out, read advances it
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ptc_tx_capture
  import ptc_pkg::*;
#(
  parameter logic [1:0] PORT_ID = 2'h0
)(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Transmit frame path, one pulse per PTP frame at egress
  input  wire logic                      tx_ptp_valid,
  input  wire logic                      tx_is_udpv4,
  input  wire logic [3:0]                tx_msg_kind,
  input  wire logic [15:0]               tx_sequence_number,
  input  wire logic [PTC_SRC_ID_W-1:0]   tx_source_identity,
  input  wire logic [31:0]               egress_seconds,
  input  wire logic [PTC_NS_W-1:0]       egress_nanoseconds,
  output logic                           tx_cf_modify,
  output logic                           tx_checksum_clear,
  // Toward the receive path for Delay_Resp insertion
  output logic [PTC_DREQ_SEC_W-1:0]      dreq_egress_seconds,
  output logic [PTC_NS_W-1:0]            dreq_egress_nanoseconds,
  output logic                           irq
);

  // Register state
  logic [2:0]                 bank_sel_r;
  logic [1:0]                 port_sel_r;
  logic                       unit_enable_r;
  logic [15:0]                correction_type_mask_r;
  logic                       sync_insert_r;
  logic                       pdresp_insert_r;
  logic                       checksum_clear_enable_r;
  logic [PTC_EV_W-1:0]        event_status_r;
  logic [PTC_EV_W-1:0]        event_mask_r;
  logic [PTC_DREQ_SEC_W-1:0]  dreq_sec_r;
  logic [PTC_NS_W-1:0]        dreq_ns_r;

  // Bus handshake
  logic                       pready_r;
  logic [31:0]                prdata_r;
  logic                       pslverr_r;
  logic [31:0]                rd_nxt;
  logic                       hit_nxt;
  logic                       port_hit;
  logic                       access;
  logic                       commit;
  logic                       wr_commit;
  logic                       rd_commit;
  logic [PTC_EV_W-1:0]        status_read_r;

  // Frame outputs
  logic                       cf_modify_r;
  logic                       checksum_clear_r;
  logic                       irq_r;
  logic                       capture_req;
  logic                       dreq_seen;
  logic [PTC_CRC_W-1:0]       source_identity_crc;

  ptc_fifo_if fif ();

  ptc_capture_fifo u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .fif     (fif.store)
  );

  ptc_port_crc u_crc (
    .src_id (tx_source_identity),
    .crc    (source_identity_crc)
  );

  // Access phase takes two cycles: data is prepared, then pready rises.
  assign access    = psel && penable;
  assign commit    = access && pready_r;
  assign wr_commit = commit && pwrite && !pslverr_r;
  assign rd_commit = commit && !pwrite && !pslverr_r;

  // Per-port space only when bank and port both select this instance
  assign port_hit = (bank_sel_r == PTC_PORT_BANK) && (port_sel_r == PORT_ID); // see R12

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (paddr)
      PTC_OFF_BANK_PORT_SEL: begin
        rd_nxt[2:0] = bank_sel_r;
        rd_nxt[PTC_PORT_SEL_LSB +: 2] = port_sel_r;
      end
      PTC_OFF_UNIT_CTRL: begin
        rd_nxt[0] = unit_enable_r;
      end
      PTC_OFF_CAPTURE_STATUS: begin
        rd_nxt[PTC_CNT_W-1:0] = fif.count; // see R6
      end
      PTC_OFF_EVENT_STATUS: begin
        rd_nxt[PTC_EV_W-1:0] = event_status_r;
      end
      PTC_OFF_EVENT_MASK: begin
        rd_nxt[PTC_EV_W-1:0] = event_mask_r;
      end
      PTC_OFF_TX_MOD: begin
        hit_nxt = port_hit;
        rd_nxt[15:0] = correction_type_mask_r;
        rd_nxt[PTC_SYNC_INSERT_BIT] = sync_insert_r;
        rd_nxt[PTC_PDRESP_INSERT_BIT] = pdresp_insert_r;
      end
      PTC_OFF_TX_MOD2: begin
        hit_nxt = port_hit;
        rd_nxt[0] = checksum_clear_enable_r;
      end
      PTC_OFF_EGRESS_SEC: begin
        hit_nxt = port_hit;
        rd_nxt = fif.rdata.sec; // see R4
      end
      PTC_OFF_EGRESS_NS: begin
        hit_nxt = port_hit;
        rd_nxt[PTC_NS_W-1:0] = fif.rdata.ns; // see R7
      end
      PTC_OFF_MSG_HEADER: begin
        hit_nxt = port_hit;
        rd_nxt = fif.rdata.header;
      end
      PTC_OFF_DREQ_SEC: begin
        hit_nxt = port_hit;
        rd_nxt[PTC_DREQ_SEC_W-1:0] = dreq_sec_r;
      end
      PTC_OFF_DREQ_NS: begin
        hit_nxt = port_hit;
        rd_nxt[PTC_NS_W-1:0] = dreq_ns_r;
      end
      default: begin
        hit_nxt = 1'b0;
      end
    endcase
    if (!hit_nxt) rd_nxt = 32'h0000_0000;
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r      <= 1'b0;
      prdata_r      <= 32'h0000_0000;
      pslverr_r     <= 1'b0;
      status_read_r <= '0;
    end else if (access && !pready_r) begin
      pready_r      <= 1'b1;
      prdata_r      <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr_r     <= !hit_nxt;
      // Snapshot lets only the bits actually returned be cleared
      status_read_r <= (!pwrite && paddr == PTC_OFF_EVENT_STATUS) ?
                       event_status_r : '0;
    end else begin
      pready_r      <= 1'b0;
      pslverr_r     <= 1'b0;
    end
  end

  // Selection and global control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_sel_r    <= '0;
      port_sel_r    <= '0;
      unit_enable_r <= 1'b0;
      event_mask_r  <= '0;
    end else if (wr_commit) begin
      case (paddr)
        PTC_OFF_BANK_PORT_SEL: begin
          bank_sel_r <= pwdata[2:0]; // see R12
          port_sel_r <= pwdata[PTC_PORT_SEL_LSB +: 2];
        end
        PTC_OFF_UNIT_CTRL:  unit_enable_r <= pwdata[0];
        PTC_OFF_EVENT_MASK: event_mask_r  <= pwdata[PTC_EV_W-1:0];
        default: ;
      endcase
    end
  end

  // Modification settings; software is trusted not to change them
  // while the unit is enabled, so no lock is imposed here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      correction_type_mask_r  <= PTC_CF_MASK_RST; // see R1
      sync_insert_r           <= 1'b0;
      pdresp_insert_r         <= 1'b0;
      checksum_clear_enable_r <= 1'b0; // see R2
    end else if (wr_commit) begin
      case (paddr)
        PTC_OFF_TX_MOD: begin
          correction_type_mask_r <= pwdata[15:0];
          sync_insert_r          <= pwdata[PTC_SYNC_INSERT_BIT];
          pdresp_insert_r        <= pwdata[PTC_PDRESP_INSERT_BIT];
        end
        PTC_OFF_TX_MOD2: checksum_clear_enable_r <= pwdata[0]; // see R3
        default: ;
      endcase
    end
  end

  // Frame modification decisions, one cycle after the frame pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cf_modify_r      <= 1'b0;
      checksum_clear_r <= 1'b0;
    end else begin
      cf_modify_r <= tx_ptp_valid && unit_enable_r &&
                     correction_type_mask_r[tx_msg_kind]; // see R1
      checksum_clear_r <= tx_ptp_valid && unit_enable_r && tx_is_udpv4 &&
                          checksum_clear_enable_r &&
                          ((sync_insert_r && tx_msg_kind == PTC_MSG_SYNC) ||
                           (pdresp_insert_r &&
                            tx_msg_kind == PTC_MSG_PDELAY_RESP)); // see R2
    end
  end

  // Capture push and read-driven pop
  assign capture_req = tx_ptp_valid && unit_enable_r;
  assign dreq_seen   = capture_req && (tx_msg_kind == PTC_MSG_DELAY_REQ);

  assign fif.push         = capture_req && !fif.full; // see R5
  // One driver for the whole entry; fields packed in capture-type order
  assign fif.wdata = {egress_seconds,
                      egress_nanoseconds, // see R7
                      source_identity_crc, // see R8
                      tx_msg_kind, tx_sequence_number}; // see R9
  // Reading the header word consumes the oldest entry
  assign fif.pop = rd_commit && (paddr == PTC_OFF_MSG_HEADER); // see R13

  // Last Delay_Req egress time, independent of the buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dreq_sec_r <= '0;
      dreq_ns_r  <= '0;
    end else if (dreq_seen) begin
      dreq_sec_r <= egress_seconds[PTC_DREQ_SEC_W-1:0]; // see R10
      dreq_ns_r  <= egress_nanoseconds;
    end
  end

  // Sticky events: a set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status_r <= '0;
    end else begin
      event_status_r <= (event_status_r &
                         ~(rd_commit ? status_read_r : '0)) |
                        {dreq_seen, capture_req && fif.full, fif.push};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(event_status_r & event_mask_r);
    end
  end

  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign tx_cf_modify            = cf_modify_r;
  assign tx_checksum_clear       = checksum_clear_r;
  assign dreq_egress_seconds     = dreq_sec_r; // see R11
  assign dreq_egress_nanoseconds = dreq_ns_r;
  assign irq                     = irq_r;

endmodule : ptc_tx_capture
`default_nettype wire

// >>> ptc_tx_monitor.sv
// Port checker for the transmit capture block.
// Bound to ptc_tx_capture; one pclk domain.
`timescale 1ns/100ps
`default_nettype none
module ptc_tx_monitor
  import ptc_pkg::*;
(
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      tx_ptp_valid,
  input wire logic                      tx_is_udpv4,
  input wire logic [3:0]                tx_msg_kind,
  input wire logic [31:0]               egress_seconds,
  input wire logic [PTC_NS_W-1:0]       egress_nanoseconds,
  input wire logic                      tx_cf_modify,
  input wire logic                      tx_checksum_clear,
  input wire logic [PTC_DREQ_SEC_W-1:0] dreq_egress_seconds,
  input wire logic [PTC_NS_W-1:0]       dreq_egress_nanoseconds
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  a_one_wait_state: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_quiet_data: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0)
    else $error("read data on write or error");
  a_cf_after_frame: assert property (tx_cf_modify |-> $past(tx_ptp_valid))
    else $error("modify pulse without frame");
  a_clear_needs_udp: assert property (tx_checksum_clear |->
    $past(tx_ptp_valid) && $past(tx_is_udpv4))
    else $error("checksum clear without udp frame");
  a_dreq_sec_source: assert property ($changed(dreq_egress_seconds) |->
    $past(tx_ptp_valid) && $past(tx_msg_kind) == PTC_MSG_DELAY_REQ &&
    dreq_egress_seconds == 4'($past(egress_seconds)))
    else $error("stored request seconds wrong");
  a_dreq_ns_source: assert property ($changed(dreq_egress_nanoseconds) |->
    $past(tx_ptp_valid) && dreq_egress_nanoseconds == $past(egress_nanoseconds))
    else $error("stored request nanoseconds wrong");
endmodule : ptc_tx_monitor

bind ptc_tx_capture ptc_tx_monitor u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .tx_ptp_valid, .tx_is_udpv4, .tx_msg_kind, .egress_seconds, .egress_nanoseconds,
  .tx_cf_modify, .tx_checksum_clear, .dreq_egress_seconds, .dreq_egress_nanoseconds
);
`default_nettype wire

// >>> ptc_frame_src.sv
// Model of the port's transmit frame path.
// Assumes pclk from the bench; fields mean something only during the pulse.
`timescale 1ns/100ps
`default_nettype none
module ptc_frame_src
  import ptc_pkg::*;
(
  input  wire logic                    pclk,
  output var  logic                    tx_ptp_valid,
  output var  logic                    tx_is_udpv4,
  output var  logic [3:0]              tx_msg_kind,
  output var  logic [15:0]             tx_sequence_number,
  output var  logic [PTC_SRC_ID_W-1:0] tx_source_identity,
  output var  logic [31:0]             egress_seconds,
  output var  logic [PTC_NS_W-1:0]     egress_nanoseconds
);
  initial begin
    tx_ptp_valid = 1'b0;
    tx_is_udpv4 = 1'b0;
    tx_msg_kind = 4'h0;
    tx_sequence_number = 16'h0000;
    tx_source_identity = '0;
    egress_seconds = 32'h0000_0000;
    egress_nanoseconds = '0;
  end

  task automatic send(input logic [3:0] k, input logic [15:0] q, input logic [31:0] s,
                      input logic [PTC_NS_W-1:0] n, input logic [79:0] id, input logic u);
    @(posedge pclk);
    tx_ptp_valid <= 1'b1;
    tx_is_udpv4 <= u;
    tx_msg_kind <= k;
    tx_sequence_number <= q;
    tx_source_identity <= id;
    egress_seconds <= s;
    egress_nanoseconds <= n;
    @(posedge pclk);
    tx_ptp_valid <= 1'b0;
    // Inverted fields so a late sample cannot match
    tx_msg_kind <= ~k;
    tx_sequence_number <= ~q;
    egress_seconds <= ~s;
    egress_nanoseconds <= ~n;
    #1;
  endtask : send
endmodule : ptc_frame_src
`default_nettype wire

// >>> ptp_tx_timestamp_capture_test.sv
// Self-checking bench for the transmit capture block.
// Assumes the frame path model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module ptp_tx_timestamp_capture_test
  import ptc_pkg::*;
();
  logic                      pclk, presetn, psel, penable, pwrite;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, egress_seconds;
  logic                      pready, pslverr, tx_cf_modify, tx_checksum_clear, irq;
  logic                      tx_ptp_valid, tx_is_udpv4;
  logic [3:0]                tx_msg_kind;
  logic [15:0]               tx_sequence_number;
  logic [PTC_SRC_ID_W-1:0]   tx_source_identity;
  logic [PTC_NS_W-1:0]       egress_nanoseconds, dreq_egress_nanoseconds;
  logic [PTC_DREQ_SEC_W-1:0] dreq_egress_seconds;
  int                        mismatches = 0;
  int                        compares = 0;
  localparam logic [31:0]    SB = 32'hA5C3_0010;
  localparam logic [29:0]    NB = 30'h2A5A_5000;
  localparam logic [79:0]    IB = 80'h0123_4567_89AB_CDEF_4200;

  ptc_tx_capture uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_ptp_valid, .tx_is_udpv4, .tx_msg_kind, .tx_sequence_number, .tx_source_identity,
    .egress_seconds, .egress_nanoseconds, .tx_cf_modify, .tx_checksum_clear,
    .dreq_egress_seconds, .dreq_egress_nanoseconds, .irq
  );
  ptc_frame_src src (
    .pclk, .tx_ptp_valid, .tx_is_udpv4, .tx_msg_kind, .tx_sequence_number,
    .tx_source_identity, .egress_seconds, .egress_nanoseconds
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic give_verdict;
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask : apb

  // Writes expect zero read data as well
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(w, a, d, q, e);
    chk(32'(e), 32'(xe));
    chk(q, x);
  endtask : acc

  task automatic fr(input logic [3:0] k, input int i, input logic u);
    src.send(k, 16'h1000 + 16'(i), SB + 32'(i), NB + 30'(i), IB + 80'(i), u);
  endtask : fr

  function automatic logic [11:0] crc12(input logic [79:0] d);
    logic [11:0] c;
    c = 12'h000;
    for (int i = 79; i >= 0; i--) begin
      c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? PTC_CRC_POLY : 12'h000);
    end
    return c;
  endfunction : crc12

  task automatic t_reset_regs;
    acc(1'b0, PTC_OFF_TX_MOD, 32'h0, 32'h0, 1'b1);
    acc(1'b1, PTC_OFF_BANK_PORT_SEL, 32'h0000_0012, 32'h0, 1'b0);
    acc(1'b0, PTC_OFF_BANK_PORT_SEL, 32'h0, 32'h0000_0012, 1'b0);
    acc(1'b1, PTC_OFF_TX_MOD, 32'h0, 32'h0, 1'b1);
    acc(1'b1, PTC_OFF_BANK_PORT_SEL, {29'h0, PTC_PORT_BANK}, 32'h0, 1'b0);
    acc(1'b0, PTC_OFF_TX_MOD, 32'h0, 32'h0000_000F, 1'b0);
    acc(1'b0, PTC_OFF_TX_MOD2, 32'h0, 32'h0, 1'b0);
    acc(1'b0, PTC_OFF_EGRESS_NS, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 12'h1F0, 32'h0, 32'h0, 1'b1);
    acc(1'b1, PTC_OFF_UNIT_CTRL, 32'h1, 32'h0, 1'b0);
  endtask : t_reset_regs

  task automatic t_capture_fifo;
    for (int i = 0; i < 5; i++) begin
      fr(4'(i), i, 1'b0);
      chk(32'(tx_cf_modify), 32'(i < 4));
    end
    chk(32'(dreq_egress_seconds), 32'((SB + 1) & 32'hF));
    chk(32'(dreq_egress_nanoseconds), 32'(NB + 1));
    acc(1'b0, PTC_OFF_DREQ_SEC, 32'h0, (SB + 1) & 32'hF, 1'b0);
    acc(1'b0, PTC_OFF_DREQ_NS, 32'h0, 32'(NB + 30'h1), 1'b0);
    acc(1'b0, PTC_OFF_CAPTURE_STATUS, 32'h0, 32'h4, 1'b0);
    acc(1'b0, PTC_OFF_EVENT_STATUS, 32'h0, 32'h7, 1'b0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, PTC_OFF_EGRESS_SEC, 32'h0, SB + 32'(i), 1'b0);
      acc(1'b0, PTC_OFF_EGRESS_NS, 32'h0, 32'(NB + 30'(i)), 1'b0);
      acc(1'b0, PTC_OFF_MSG_HEADER, 32'h0,
          {crc12(IB + 80'(i)), 4'(i), 16'h1000 + 16'(i)}, 1'b0);
      acc(1'b0, PTC_OFF_CAPTURE_STATUS, 32'h0, 32'(3 - i), 1'b0);
    end
    acc(1'b0, PTC_OFF_EGRESS_SEC, 32'h0, 32'h0, 1'b0);
  endtask : t_capture_fifo

  task automatic t_type_mask;
    acc(1'b1, PTC_OFF_TX_MOD, 32'h0000_A5A5, 32'h0, 1'b0);
    acc(1'b0, PTC_OFF_TX_MOD, 32'h0, 32'h0000_A5A5, 1'b0);
    for (int k = 0; k < 16; k++) begin
      fr(4'(k), k, 1'b0);
      chk(32'(tx_cf_modify), 32'((16'hA5A5 >> k) & 16'h1));
    end
  endtask : t_type_mask

  task automatic t_checksum;
    logic [3:0] k;
    acc(1'b1, PTC_OFF_UNIT_CTRL, 32'h0, 32'h0, 1'b0);
    fr(PTC_MSG_SYNC, 9, 1'b1);
    chk(32'(tx_cf_modify), 32'h0);
    acc(1'b1, PTC_OFF_TX_MOD2, 32'h1, 32'h0, 1'b0);
    acc(1'b0, PTC_OFF_TX_MOD2, 32'h0, 32'h1, 1'b0);
    acc(1'b1, PTC_OFF_UNIT_CTRL, 32'h1, 32'h0, 1'b0);
    for (int j = 0; j < 2; j++) begin
      acc(1'b1, PTC_OFF_TX_MOD, 32'h1000_0000 << j, 32'h0, 1'b0);
      for (int c = 0; c < 3; c++) begin
        k = ((j == 1) ^ (c == 1)) ? PTC_MSG_PDELAY_RESP : PTC_MSG_SYNC;
        fr(k, c, 1'(c != 2));
        chk(32'(tx_checksum_clear), 32'(c == 0));
      end
    end
  endtask : t_checksum

  task automatic t_interrupt;
    logic [31:0] q;
    logic        e;
    apb(1'b0, PTC_OFF_EVENT_STATUS, 32'h0, q, e);
    acc(1'b1, PTC_OFF_EVENT_MASK, 32'h2, 32'h0, 1'b0);
    fr(4'h2, 0, 1'b0);
    @(posedge pclk);
    #1;
    chk(32'(irq), 32'h1);
    acc(1'b0, PTC_OFF_EVENT_STATUS, 32'h0, 32'h2, 1'b0);
    @(posedge pclk);
    #1;
    chk(32'(irq), 32'h0);
    acc(1'b1, PTC_OFF_EVENT_MASK, 32'h0, 32'h0, 1'b0);
    fr(4'h2, 1, 1'b0);
    @(posedge pclk);
    #1;
    chk(32'(irq), 32'h0);
  endtask : t_interrupt

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_regs();
    t_capture_fifo();
    t_type_mask();
    t_checksum();
    t_interrupt();
    give_verdict();
  end
endmodule : ptp_tx_timestamp_capture_test
`default_nettype wire
